// >>> hw/fpm_map.svh
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPM_CLK_KHZ        200000
`define FPM_IDLE_MS        12000
`define FPM_SHOW_MS        1000

// ----------------------------------------
// Menu indices, zero is the save prompt
// ----------------------------------------
`define FPM_M_SAVE         4'h0
`define FPM_M_UP_FREQ      4'h1
`define FPM_M_UP_LEVEL     4'h2
`define FPM_M_UP_GAIN      4'h3
`define FPM_M_DN_FREQ      4'h4
`define FPM_M_DN_GAIN      4'h5
`define FPM_M_MUTE         4'h6
`define FPM_M_REMOTE       4'h7
`define FPM_M_SPEC         4'h8
`define FPM_M_EXT_REF      4'h9
`define FPM_M_MODE         4'hA
`define FPM_M_ADDR         4'hB
`define FPM_M_TEMP         4'hC
`define FPM_M_CURR         4'hD
`define FPM_M_LAST         4'hD

// ----------------------------------------
// Setting ranges
// ----------------------------------------
`define FPM_FREQ_LO        18'sh0099C
`define FPM_FREQ_HI        18'sh009EC
`define FPM_LEVEL_LO       -18'sh00028
`define FPM_LEVEL_HI       -18'sh0000A
`define FPM_UPG_LO         -18'sh0000A
`define FPM_UPG_HI         18'sh0001E
`define FPM_DNG_LO         18'sh00000
`define FPM_DNG_HI         18'sh00032
`define FPM_ADDR_LO        18'sh00000
`define FPM_ADDR_HI        18'sh0001F

// ----------------------------------------
// Register offsets and option bits
// ----------------------------------------
`define FPM_REG_STATUS     8'h00
`define FPM_REG_OPTIONS    8'h04
`define FPM_REG_FREQ       8'h08
`define FPM_REG_LEVELS     8'h0C
`define FPM_REG_FLAGS      8'h10
`define FPM_OPT_E          0
`define FPM_OPT_Q          1
`define FPM_OPT_T          2
`define FPM_OPT_L          3
`define FPM_OPT_V          4
`define FPM_OPT_RESET      5'h00
`define FPM_SW_VERSION     8'h10

`endif

// >>> hw/fpm_pkg.sv
package fpm_pkg;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    FPM_ST_LOAD   = 3'b000,
    FPM_ST_SEGS   = 3'b001,
    FPM_ST_VER    = 3'b010,
    FPM_ST_NORMAL = 3'b011,
    FPM_ST_EDIT   = 3'b100,
    FPM_ST_SAVE   = 3'b101,
    FPM_ST_DONE   = 3'b110
  } fpm_state_e;

  // ----------------------------------------
  // One full set of operator settings
  // ----------------------------------------
  typedef struct packed {
    logic [15:0]        up_freq;
    logic [15:0]        dn_freq;
    logic signed [7:0]  up_input_level_field;
    logic signed [7:0]  up_gain;
    logic [7:0]         down_gain_field;
    logic               mute;
    logic               remote;
    logic               spec_inv;
    logic               ext_ref;
    logic               multidrop;
    logic [4:0]         bus_addr;
  } fpm_set_s;

endpackage

// >>> hw/fpm_ctrl.sv
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "fpm_map.svh"


module fpm_ctrl
  import fpm_pkg::*;
#(
  parameter logic [31:0] IDLE_CYC = 32'(64'(`FPM_IDLE_MS) * 64'(`FPM_CLK_KHZ)),
  parameter logic [31:0] SHOW_CYC = 32'(64'(`FPM_SHOW_MS) * 64'(`FPM_CLK_KHZ))
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        key_exec_i,
  input  wire logic        rock_left_i,
  input  wire logic        rock_right_i,
  input  wire logic        rock_up_i,
  input  wire logic        rock_down_i,
  input  wire logic        up_pll_lock_i,
  input  wire logic        dn_pll_lock_i,
  input  wire fpm_set_s    nv_image_i,
  output fpm_set_s         nv_image_o,
  output logic             nv_save_o,
  output fpm_set_s         hw_set_o,
  output fpm_state_e       disp_mode_o,
  output logic      [3:0]  disp_menu_o,
  output logic      [2:0]  disp_cursor_o,
  output logic             disp_yes_o,
  output logic      [7:0]  disp_version_o,
  output logic             alarm_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic [6:0]  prev;
    fpm_state_e  state;
    logic [3:0]  menu;
    logic [2:0]  cursor;
    logic        yes;
    logic [31:0] cnt;
    logic [31:0] idle;
    fpm_set_s    committed;
    fpm_set_s    working;
    logic        nv_save;
    logic        alarm;
    logic [4:0]  options;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  version;
  } fpm_reg_s;

  fpm_reg_s r;
  fpm_reg_s next_r;

  // ----------------------------------------
  // Menu decoding
  // ----------------------------------------

  // Number of digit positions a menu edits; zero for on/off and view menus.
  function automatic logic [2:0] fpm_digits(input logic [3:0] m);
    case (m)
      `FPM_M_UP_FREQ, `FPM_M_DN_FREQ: fpm_digits = 3'd4;
      `FPM_M_UP_LEVEL:                fpm_digits = 3'd1;
      `FPM_M_UP_GAIN, `FPM_M_DN_GAIN: fpm_digits = 3'd2;
      `FPM_M_ADDR:                    fpm_digits = 3'd2;
      default:                        fpm_digits = 3'd0;
    endcase
  endfunction

  // True for the on/off menus that the vertical rocker toggles.
  function automatic logic fpm_is_toggle(input logic [3:0] m);
    fpm_is_toggle = (m >= `FPM_M_MUTE) && (m <= `FPM_M_MODE);
  endfunction

  // True when the menu exists on this unit's option set.
  function automatic logic fpm_fitted(input logic [3:0] m, input logic [4:0] o);
    case (m)
      `FPM_M_EXT_REF: fpm_fitted = o[`FPM_OPT_E];
      `FPM_M_MODE,
      `FPM_M_ADDR:    fpm_fitted = o[`FPM_OPT_Q];
      `FPM_M_TEMP:    fpm_fitted = o[`FPM_OPT_T];
      `FPM_M_CURR:    fpm_fitted = o[`FPM_OPT_L] | o[`FPM_OPT_V];
      default:        fpm_fitted = 1'b1;
    endcase
  endfunction

  // Next fitted menu after m, or the save prompt after the last one.
  function automatic logic [3:0] fpm_next(input logic [3:0] m, input logic [4:0] o);
    logic [3:0] res;
    res = `FPM_M_SAVE;
    for (int i = `FPM_M_LAST; i >= 1; i--) begin
      if ((4'(i) > m) && fpm_fitted(4'(i), o)) begin
        res = 4'(i);
      end
    end
    fpm_next = res;
  endfunction

  // Weight of the digit under the cursor; position 0 is the return marker.
  function automatic logic signed [17:0] fpm_weight(input logic [2:0] c);
    case (c)
      3'd2:    fpm_weight = 18'sh0000A;
      3'd3:    fpm_weight = 18'sh00064;
      3'd4:    fpm_weight = 18'sh003E8;
      default: fpm_weight = 18'sh00001;
    endcase
  endfunction

  // Lower and upper limit of a numeric menu.
  function automatic logic signed [35:0] fpm_limits(input logic [3:0] m);
    case (m)
      `FPM_M_UP_FREQ, `FPM_M_DN_FREQ: fpm_limits = {`FPM_FREQ_LO, `FPM_FREQ_HI};
      `FPM_M_UP_LEVEL: fpm_limits = {`FPM_LEVEL_LO, `FPM_LEVEL_HI};
      `FPM_M_UP_GAIN:  fpm_limits = {`FPM_UPG_LO, `FPM_UPG_HI};
      `FPM_M_DN_GAIN:  fpm_limits = {`FPM_DNG_LO, `FPM_DNG_HI};
      default:         fpm_limits = {`FPM_ADDR_LO, `FPM_ADDR_HI};
    endcase
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic [4:0]         ev;
  logic               any_ev;
  logic [2:0]         npos;
  logic [3:0]         nxt;
  logic signed [17:0] val;
  logic signed [17:0] lo;
  logic signed [17:0] hi;
  logic               wb_req;

  // Switch edges, menu walk, editing, save prompt, idle timeout and bus.
  always_comb begin
    next_r       = r;
    next_r.sync1 = {dn_pll_lock_i, up_pll_lock_i, rock_down_i, rock_up_i,
                    rock_right_i, rock_left_i, key_exec_i};
    next_r.sync2 = r.sync1;
    next_r.prev  = r.sync2;

    // Rising edges compare the second stage with its value one cycle older.
    ev           = r.sync2[4:0] & ~r.prev[4:0];
    any_ev       = |ev;
    npos         = (fpm_digits(r.menu) == 3'd0) ? 3'd1 : fpm_digits(r.menu);
    nxt          = fpm_next(r.menu, r.options);
    {lo, hi}     = fpm_limits(r.menu);
    val          = 18'sh00000;

    // One-cycle store pulse, synced alarm and version.
    next_r.nv_save = 1'b0;
    next_r.alarm   = ~(r.sync2[5] & r.sync2[6]);
    next_r.version = `FPM_SW_VERSION;
    // Idle time counts in every state except normal display, and restarts on any rising switch edge.
    next_r.idle = (any_ev || r.state == FPM_ST_NORMAL) ? 32'h0 : r.idle + 32'h1;

    // Value of the field under edit.
    case (r.menu)
      `FPM_M_UP_FREQ:  val = 18'(r.working.up_freq);
      `FPM_M_DN_FREQ:  val = 18'(r.working.dn_freq);
      `FPM_M_UP_LEVEL: val = 18'(r.working.up_input_level_field);
      `FPM_M_UP_GAIN:  val = 18'(r.working.up_gain);
      `FPM_M_DN_GAIN:  val = 18'(r.working.down_gain_field);
      default:         val = 18'(r.working.bus_addr);
    endcase

    if (ev[3]) begin
      val = val + fpm_weight(r.cursor);
    end else begin
      val = val - fpm_weight(r.cursor);
    end
    if (val < lo) begin
      val = lo;
    end else if (val > hi) begin
      val = hi;
    end

    // Power-up, menu walk, edits and save prompt.
    case (r.state)
      FPM_ST_LOAD: begin
        // Image is read once after reset.
        next_r.committed = nv_image_i;
        next_r.working   = nv_image_i;
        next_r.cnt       = 32'h0;
        next_r.state     = FPM_ST_SEGS;
      end
      FPM_ST_SEGS, FPM_ST_VER: begin
        next_r.cnt = r.cnt + 32'h1;
        if (r.cnt >= SHOW_CYC - 32'h1) begin
          next_r.cnt   = 32'h0;
          next_r.state = (r.state == FPM_ST_SEGS) ? FPM_ST_VER : FPM_ST_NORMAL;
        end
      end
      FPM_ST_NORMAL: begin
        if (ev[0]) begin
          next_r.menu   = fpm_next(4'h0, r.options);
          next_r.cursor = 3'd1;
          next_r.state  = FPM_ST_EDIT;
        end
      end
      FPM_ST_EDIT: begin
        if (ev[0]) begin
          if (r.cursor == 3'd0 || nxt == `FPM_M_SAVE) begin
            next_r.state = FPM_ST_SAVE;
            next_r.yes   = 1'b1;
          end else begin
            next_r.menu   = nxt;
            next_r.cursor = 3'd1;
          end
        end else if (ev[1] && r.cursor < npos) begin
          next_r.cursor = r.cursor + 3'd1;
        end else if (ev[2] && r.cursor != 3'd0) begin
          next_r.cursor = r.cursor - 3'd1;
        end else if ((ev[3] || ev[4]) && r.cursor != 3'd0) begin
          if (fpm_is_toggle(r.menu)) begin
            case (r.menu)
              `FPM_M_MUTE:    next_r.working.mute      = ~r.working.mute;
              `FPM_M_REMOTE:  next_r.working.remote    = ~r.working.remote;
              `FPM_M_SPEC:    next_r.working.spec_inv  = ~r.working.spec_inv;
              `FPM_M_EXT_REF: next_r.working.ext_ref   = ~r.working.ext_ref;
              default:        next_r.working.multidrop = ~r.working.multidrop;
            endcase
          end else begin
            // View menus have no digits and ignore the vertical rocker.
            case (r.menu)
              `FPM_M_UP_FREQ:  next_r.working.up_freq = val[15:0];
              `FPM_M_DN_FREQ:  next_r.working.dn_freq = val[15:0];
              `FPM_M_UP_LEVEL: next_r.working.up_input_level_field = val[7:0];
              `FPM_M_UP_GAIN:  next_r.working.up_gain = val[7:0];
              `FPM_M_DN_GAIN:  next_r.working.down_gain_field = val[7:0];
              `FPM_M_ADDR:     next_r.working.bus_addr = val[4:0];
              default:         next_r.working = r.working;
            endcase
          end
        end
      end
      FPM_ST_SAVE: begin
        // Either direction flips the choice.
        if (ev[3] || ev[4]) begin
          next_r.yes = ~r.yes;
        end else if (ev[0]) begin
          if (r.yes) begin
            next_r.committed = r.working;
            next_r.nv_save   = 1'b1;
          end else begin
            next_r.working = r.committed;
          end
          next_r.state = FPM_ST_DONE;
        end
      end
      FPM_ST_DONE: begin
        // No idle timeout once settled.
        if (ev[0]) begin
          next_r.state = FPM_ST_NORMAL;
        end
      end
      default: begin
        next_r.state = FPM_ST_LOAD;
      end
    endcase

    // Idle expiry before the confirming press drops every pending edit.
    if ((r.state == FPM_ST_EDIT || r.state == FPM_ST_SAVE) && !any_ev &&
        r.idle >= IDLE_CYC - 32'h1) begin
      next_r.working = r.committed;
      next_r.state   = FPM_ST_NORMAL;
    end

    // Classic Wishbone slave: one wait state, ack for one cycle.
    wb_req       = wb_cyc_i & wb_stb_i & ~r.ack;
    next_r.ack   = wb_req;
    next_r.rdata = 32'h0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `FPM_REG_STATUS:  next_r.rdata = {16'h0, r.alarm, r.yes, r.cursor, r.menu,
                                          2'b00, r.sync2[6:5], r.state};
        `FPM_REG_OPTIONS: next_r.rdata = {27'h0, r.options};
        `FPM_REG_FREQ:    next_r.rdata = {r.committed.dn_freq, r.committed.up_freq};
        `FPM_REG_LEVELS:  next_r.rdata = {8'h0, r.committed.down_gain_field,
                                          r.committed.up_gain, r.committed.up_input_level_field};
        `FPM_REG_FLAGS:   next_r.rdata = {22'h0, r.committed.bus_addr, r.committed.multidrop,
                                          r.committed.ext_ref, r.committed.spec_inv,
                                          r.committed.remote, r.committed.mute};
        default:          next_r.rdata = 32'h0;
      endcase
    end
    if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `FPM_REG_OPTIONS) begin
      next_r.options = wb_dat_i[4:0];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Synchronous reset to power-up load; storage image is caught after release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_r_reset: begin
        // Alarm stays up until locks are synced.
        r         <= '0;
        r.state   <= FPM_ST_LOAD;
        r.options <= `FPM_OPT_RESET;
        r.alarm   <= 1'b1;
      end
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Frequencies and on/off flags follow committed values, level and gains the edits.
  assign hw_set_o = '{up_freq:              r.committed.up_freq,
                      dn_freq:              r.committed.dn_freq,
                      up_input_level_field: r.working.up_input_level_field,
                      up_gain:              r.working.up_gain,
                      down_gain_field:      r.working.down_gain_field,
                      mute:                 r.committed.mute,
                      remote:               r.committed.remote,
                      spec_inv:             r.committed.spec_inv,
                      ext_ref:              r.committed.ext_ref,
                      multidrop:            r.committed.multidrop,
                      bus_addr:             r.committed.bus_addr};

  // Remaining outputs are plain register fields.
  assign nv_image_o     = r.committed;
  assign nv_save_o      = r.nv_save;
  assign disp_mode_o    = r.state;
  assign disp_menu_o    = r.menu;
  assign disp_cursor_o  = r.cursor;
  assign disp_yes_o     = r.yes;
  assign disp_version_o = r.version;
  assign alarm_o        = r.alarm;

  // Bus answer is registered as well.
  assign wb_dat_o       = r.rdata;
  assign wb_ack_o       = r.ack;

endmodule // fpm_ctrl

// >>> tb/fpm_ctrl_properties.sv
`timescale 1ns/1ps
module fpm_ctrl_properties
  import fpm_pkg::*;
#(
  parameter logic [31:0] IDLE_CYC = 32'd200,
  parameter logic [31:0] SHOW_CYC = 32'd4
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       up_pll_lock_i,
  input wire logic       alarm_o,
  input wire fpm_set_s   nv_image_o,
  input wire logic       nv_save_o,
  input wire fpm_set_s   hw_set_o,
  input wire fpm_state_e disp_mode_o,
  input wire logic [3:0] disp_menu_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // All checks run on the one clock and rest while reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Power-up display steps, each leaving for the next.
  sequence segs_end;
    disp_mode_o == FPM_ST_SEGS ##1 disp_mode_o != FPM_ST_SEGS;
  endsequence
  sequence ver_end;
    disp_mode_o == FPM_ST_VER ##1 disp_mode_o != FPM_ST_VER;
  endsequence

  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held two cycles");
  alarm_raise_a: assert property ($fell(up_pll_lock_i) |-> ##[1:4] alarm_o)
    else $error("alarm missing after lock loss");
  save_step_a: assert property (nv_save_o |-> disp_mode_o == FPM_ST_DONE && $past(disp_mode_o) == FPM_ST_SAVE)
    else $error("store pulse outside a confirmed save");
  commit_gate_a: assert property ($changed(nv_image_o) && $past(disp_mode_o) != FPM_ST_LOAD |-> nv_save_o)
    else $error("committed settings changed without a save");
  freq_apply_a: assert property ($changed({hw_set_o.up_freq, hw_set_o.dn_freq})
    && $past(disp_mode_o) != FPM_ST_LOAD |-> nv_save_o)
    else $error("frequency applied before a save");
  level_range_a: assert property (disp_mode_o != FPM_ST_LOAD |->
    $signed(hw_set_o.up_input_level_field) >= -40 && $signed(hw_set_o.up_input_level_field) <= -10)
    else $error("input level out of range");
  gain_range_a: assert property (disp_mode_o != FPM_ST_LOAD |-> $signed(hw_set_o.up_gain) >= -10
    && $signed(hw_set_o.up_gain) <= 30 && hw_set_o.down_gain_field <= 8'h32)
    else $error("gain out of range");
  menu_range_a: assert property (disp_mode_o == FPM_ST_EDIT |-> disp_menu_o inside {[4'h1:4'hD]})
    else $error("menu index out of range");
  boot_segs_a: assert property (segs_end |-> disp_mode_o == FPM_ST_VER)
    else $error("segment step not followed by version");
  boot_ver_a: assert property (ver_end |-> disp_mode_o == FPM_ST_NORMAL)
    else $error("version step not followed by normal display");
endmodule // fpm_ctrl_properties

bind fpm_ctrl fpm_ctrl_properties #(.IDLE_CYC(IDLE_CYC), .SHOW_CYC(SHOW_CYC)) fpm_ctrl_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .up_pll_lock_i(up_pll_lock_i), .alarm_o(alarm_o), .nv_image_o(nv_image_o), .nv_save_o(nv_save_o),
  .hw_set_o(hw_set_o), .disp_mode_o(disp_mode_o), .disp_menu_o(disp_menu_o));

// >>> tb/fpm_operator_panel.sv
`timescale 1ns/1ps
module fpm_operator_panel
  import fpm_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     nv_save_i,
  input  wire fpm_set_s nv_data_i,
  output logic [4:0]    sw_o,
  output fpm_set_s      nv_image_o
);
  // Switch pins rest low; an operation is one clean high pulse.
  initial sw_o = 5'h00;

  // The store keeps the last committed image across a controller reset.
  always @(posedge clk_i) begin
    if (nv_save_i) begin
      nv_image_o <= nv_data_i;
    end
  end

  // Press one switch for a number of cycles, then release and rest.
  task automatic press(input int k, input int hold);
    sw_o[k] <= 1'b1;
    repeat (hold) @(posedge clk_i);
    sw_o[k] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // Fill the store before power is applied.
  task automatic preset(input fpm_set_s img);
    nv_image_o <= img;
  endtask
endmodule // fpm_operator_panel

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "fpm_map.svh"
module testbench;
  import fpm_pkg::*;
  localparam int EXEC = 0, LEFT = 1, RIGHT = 2, UP = 3, DOWN = 4;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, nv_save_o;
  logic        up_pll_lock_i, dn_pll_lock_i, disp_yes_o, alarm_o;
  logic [7:0]  wb_adr_i, disp_version_o;
  logic [3:0]  wb_sel_i, disp_menu_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [4:0]  sw;
  logic [2:0]  disp_cursor_o;
  fpm_set_s    nv_image_i, nv_image_o, hw_set_o, img;
  fpm_state_e  disp_mode_o;
  int          failures = 0, check_count = 0;

  // ----------------------------------------
  // Clock, design and operator
  // ----------------------------------------
  // A 200 MHz clock.
  always #2.5 clk_i = ~clk_i;

  fpm_ctrl #(.IDLE_CYC(32'd200), .SHOW_CYC(32'd4)) fpm_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .key_exec_i(sw[0]), .rock_left_i(sw[1]), .rock_right_i(sw[2]), .rock_up_i(sw[3]), .rock_down_i(sw[4]),
    .up_pll_lock_i(up_pll_lock_i), .dn_pll_lock_i(dn_pll_lock_i), .nv_image_i(nv_image_i),
    .nv_image_o(nv_image_o), .nv_save_o(nv_save_o), .hw_set_o(hw_set_o), .disp_mode_o(disp_mode_o),
    .disp_menu_o(disp_menu_o), .disp_cursor_o(disp_cursor_o), .disp_yes_o(disp_yes_o),
    .disp_version_o(disp_version_o), .alarm_o(alarm_o));
  fpm_operator_panel fpm_operator_panel_i (.clk_i(clk_i), .nv_save_i(nv_save_o), .nv_data_i(nv_image_o),
    .sw_o(sw), .nv_image_o(nv_image_i));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One classic bus cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'hF;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    check(n, 2, "bus ack latency");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Slow presses on the execute key, quick ones on the rockers.
  task automatic op(input int k);
    fpm_operator_panel_i.press(k, (k == EXEC) ? 9 : 2);
  endtask

  task automatic ops(input int k, input int n);
    repeat (n) op(k);
  endtask

  // Leave the save prompt with the given choice and come back to normal display.
  task automatic finish_save(input logic yes);
    check(disp_mode_o, FPM_ST_SAVE, "save prompt");
    check(disp_yes_o, 1'b1, "default yes");
    if (!yes) op(UP);
    op(EXEC);
    check(disp_mode_o, FPM_ST_DONE, "save done");
    op(EXEC);
    check(disp_mode_o, FPM_ST_NORMAL, "back to normal");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    int seen;
    seen = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (disp_mode_o === FPM_ST_VER) seen = 1;
    end
    check(seen, 1, "version step");
    check(disp_mode_o, FPM_ST_NORMAL, "normal display");
    check(disp_version_o, `FPM_SW_VERSION, "version");
    check({hw_set_o.up_freq, hw_set_o.dn_freq}, {img.up_freq, img.dn_freq}, "restored freq");
    check(hw_set_o.up_input_level_field, img.up_input_level_field, "restored level");
    $display("test boot done");
  endtask

  task automatic t_regs();
    wb(1'b0, `FPM_REG_OPTIONS, 32'h0);
    check(q, 32'h0, "options reset");
    wb(1'b1, `FPM_REG_OPTIONS, 32'hFFFFFFFF);
    wb(1'b0, `FPM_REG_OPTIONS, 32'h0);
    check(q, 32'h1F, "options bits");
    wb(1'b1, `FPM_REG_FREQ, 32'h0);
    wb(1'b0, `FPM_REG_FREQ, 32'h0);
    check(q, {img.dn_freq, img.up_freq}, "freq read only");
    wb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0, "unmapped read");
    $display("test registers done");
  endtask

  task automatic t_menu();
    for (int m = 1; m <= 13; m++) begin
      op(EXEC);
      check(disp_menu_o, m, "menu order");
    end
    op(EXEC);
    finish_save(1'b0);
    wb(1'b1, `FPM_REG_OPTIONS, 32'h0);
    ops(EXEC, 8);
    check(disp_menu_o, 8, "last plain menu");
    op(EXEC);
    finish_save(1'b1);
    wb(1'b1, `FPM_REG_OPTIONS, 32'h1F);
    $display("test menu done");
  endtask

  task automatic t_level();
    ops(EXEC, 2);
    op(UP);
    check(hw_set_o.up_input_level_field, -10, "level live");
    op(UP);
    check(hw_set_o.up_input_level_field, -10, "level clamp");
    ops(DOWN, 2);
    check(hw_set_o.up_input_level_field, -12, "level down");
    check(nv_image_o.up_input_level_field, -11, "level not stored");
    op(RIGHT);
    check(disp_cursor_o, 3'h0, "return marker");
    op(EXEC);
    finish_save(1'b1);
    check(nv_image_i.up_input_level_field, -12, "level stored");
    wb(1'b0, `FPM_REG_LEVELS, 32'h0);
    check(q, {8'h0, img.down_gain_field, img.up_gain, 8'hF4}, "levels reg");
    $display("test level done");
  endtask

  task automatic t_freq();
    op(EXEC);
    op(LEFT);
    check(disp_cursor_o, 3'h2, "cursor left");
    op(UP);
    check(hw_set_o.up_freq, img.up_freq, "freq held");
    ops(RIGHT, 2);
    op(EXEC);
    finish_save(1'b1);
    check(hw_set_o.up_freq, img.up_freq + 16'd10, "freq applied");
    $display("test frequency done");
  endtask

  task automatic t_gain();
    ops(EXEC, 5);
    op(LEFT);
    op(UP);
    check(hw_set_o.down_gain_field, 35, "gain tens");
    ops(UP, 2);
    check(hw_set_o.down_gain_field, 50, "gain clamp");
    ops(RIGHT, 2);
    op(EXEC);
    finish_save(1'b0);
    check(hw_set_o.down_gain_field, img.down_gain_field, "gain reverted");
    $display("test gain done");
  endtask

  task automatic t_mute();
    ops(EXEC, 6);
    op(UP);
    op(DOWN);
    op(UP);
    check(hw_set_o.mute, 1'b0, "mute held");
    op(RIGHT);
    op(EXEC);
    finish_save(1'b1);
    check(hw_set_o.mute, 1'b1, "mute toggled");
    $display("test mute done");
  endtask

  task automatic t_idle();
    ops(EXEC, 2);
    op(DOWN);
    repeat (150) @(posedge clk_i);
    op(DOWN);
    repeat (150) @(posedge clk_i);
    check(disp_mode_o, FPM_ST_EDIT, "timer restarted");
    check(hw_set_o.up_input_level_field, -14, "level live");
    repeat (100) @(posedge clk_i);
    check(disp_mode_o, FPM_ST_NORMAL, "timeout");
    check(hw_set_o.up_input_level_field, -12, "timeout reverts");
    $display("test timeout done");
  endtask

  task automatic t_alarm();
    up_pll_lock_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(alarm_o, 1'b1, "alarm up");
    up_pll_lock_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(alarm_o, 1'b0, "alarm clear");
    dn_pll_lock_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(alarm_o, 1'b1, "alarm down");
    dn_pll_lock_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    $display("test alarm done");
  endtask

  task automatic t_power();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    check(hw_set_o.up_freq, img.up_freq + 16'd10, "freq kept");
    check(hw_set_o.mute, 1'b1, "mute kept");
    $display("test power cycle done");
  endtask

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: power up with a stored image and run every scenario.
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    up_pll_lock_i = 1'b1;
    dn_pll_lock_i = 1'b1;
    img = '0;
    img.up_freq = 16'd2500;
    img.dn_freq = 16'd2480;
    img.up_input_level_field = -8'sd11;
    img.up_gain = 8'sd10;
    img.down_gain_field = 8'd25;
    fpm_operator_panel_i.preset(img);
    repeat (20) @(posedge clk_i);
    check(alarm_o, 1'b1, "alarm in reset");
    rst_i <= 1'b0;
    t_boot();
    t_regs();
    t_menu();
    t_level();
    t_freq();
    t_gain();
    t_mute();
    t_idle();
    t_alarm();
    t_power();
    end_of_test();
  end

  // Watchdog: the run needs a few thousand cycles at most.
  initial begin
    #100000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // testbench
